//--- aos_defines.svh
/*
  Register offsets, field positions and reset values of the output,
  status, detection and trim register bank.
  Assumes a 6-bit register address from the serial protocol engine.
*/
`ifndef AOS_DEFINES_SVH
`define AOS_DEFINES_SVH

// Register offsets
`define AOS_ADDR_Z_LOW      6'h04
`define AOS_ADDR_Z_HIGH     6'h05
`define AOS_ADDR_X_BYTE     6'h06
`define AOS_ADDR_Y_BYTE     6'h07
`define AOS_ADDR_Z_BYTE     6'h08
`define AOS_ADDR_STATUS     6'h09
`define AOS_ADDR_DETECTION_SOURCE     6'h0A
`define AOS_ADDR_BUS_ADDR   6'h0D
`define AOS_ADDR_USER_INFO  6'h0E
`define AOS_ADDR_IDENT      6'h0F
`define AOS_ADDR_X_OFFSET_TRIM_LOW   6'h10
`define AOS_ADDR_X_OFFSET_TRIM_HIGH  6'h11
`define AOS_ADDR_Y_OFFSET_TRIM_LOW   6'h12
`define AOS_ADDR_Y_OFFSET_TRIM_HIGH  6'h13

// Field positions
`define AOS_STAT_READY      0
`define AOS_STAT_OVERRUN    1
`define AOS_STAT_PARITY     2
`define AOS_DET_FIRST_INTERRUPT_FLAG        0
`define AOS_DET_SECOND_INTERRUPT_FLAG        1
`define AOS_BUSAD_DISABLE   7

// Interrupt assignment encodings
`define AOS_ASSIGN_LVL_PUL  2'b00
`define AOS_ASSIGN_PUL_LVL  2'b01
`define AOS_ASSIGN_PUL_PUL  2'b10

// Reset values
`define AOS_RST_BYTE        8'h00
`define AOS_RST_SLAVE_ADDR  7'h1D
`define AOS_RST_TRIM        11'h000

`endif

//--- aos_pkg.sv
/*
  Types of the output, status, detection and trim register bank.
  Assumes the defines header is compiled alongside.
*/
package aos_pkg;

  // One sample from the sensing path, in half-count units
  typedef struct packed {
    logic [10:0] x;
    logic [10:0] y;
    logic [10:0] z;
  } aos_sample_t;

  // Register access strobe and data from the protocol engine
  typedef struct packed {
    logic       wr_en;
    logic       rd_en;
    logic [5:0] addr;
    logic [7:0] wr_data;
  } aos_reg_req_t;

  // Detection events from the level and pulse detectors
  typedef struct packed {
    logic [2:0] level_hit;  // x, y, z
    logic [2:0] pulse_hit;  // x, y, z
    logic       double_hit;
  } aos_det_evt_t;

  // Whole state of the bank
  typedef struct packed {
    logic [9:0]  x_out;
    logic [9:0]  y_out;
    logic [9:0]  z_out;
    logic [1:0]  z_high_held;
    logic        ready;
    logic        overrun;
    logic        parity_err;
    logic [2:0]  level_flags;
    logic [2:0]  pulse_flags;
    logic        first_interrupt_flag_flag;
    logic        second_interrupt_flag_flag;
    logic        two_wire_dis;
    logic [10:0] x_trim;
    logic [10:0] y_trim;
    logic [7:0]  rd_data;
    logic        rd_valid;
  } aos_state_t;

endpackage

//--- aos_regs.sv
/*
  Output, status, detection-source, bus-address, identification and
  X/Y offset trim registers of a three-axis accelerometer.
  Assumes a protocol engine on clk_sys issues one-cycle read and write
  strobes, and that sensing, detection and fuse logic share clk_sys.
*/
// What this block does
// - Low Z read latches matching high bits
// - Ten-bit outputs two's complement, high bits 1:0
// - Byte outputs signed at consecutive offsets
// - Status bit 0 flags new sample ready
// - Status bit 1 flags overwritten sample
// - Status bit 2 parity error, blocks self-test
// - Level hits per axis in bits 7:5
// - Pulse hits per axis in bits 4:2
// - Pulse axis flags meaningless in double-pulse mode
// - Bits 0/1 flag assigned interrupt sources
// - Address bit 7 writable disables two-wire bus
// - Address bits 6:0 return slave address
// - User and identification bytes read-only fused
// - Signed per-axis trim, applied to output
// - Trim bit 0 half count, bit 10 sign
// - Same trim weights in ten-bit wide range
// - Trim keeps host-written calibration values
// - Interrupt clear drops flag and axis flags of its assigned source
`timescale 1ns/1ps
`include "aos_defines.svh"
`default_nettype none

module aos_regs #(
  parameter logic [6:0] SLAVE_ADDR = `AOS_RST_SLAVE_ADDR,
  parameter int         ADDR_W     = 6
) (
  // Clock and reset
  input  wire logic                 clk_sys,
  input  wire logic                 rst_n,
  // Register access from the protocol engine
  input  wire aos_pkg::aos_reg_req_t reg_req,
  output logic [7:0]                reg_rd_data,
  output logic                      reg_rd_valid,
  // Sensing path
  input  wire logic                 sample_valid,
  input  wire aos_pkg::aos_sample_t sample_raw,
  // Detection and configuration
  input  wire aos_pkg::aos_det_evt_t det_evt,
  input  wire logic [1:0]           interrupt_assignment_field,
  input  wire logic                 double_pulse_active,
  input  wire logic                 first_interrupt_clear,
  input  wire logic                 second_interrupt_clear,
  input  wire logic                 ready_pin_routing_bit,
  // Trim and fuse block
  input  wire logic                 trim_parity_error,
  input  wire logic [7:0]           otp_user_info,
  input  wire logic [7:0]           otp_ident,
  // Outputs to the rest of the device
  output logic                      two_wire_disable_bit,
  output logic                      self_test_block,
  output logic                      first_int_pin,
  output logic                      second_int_pin
);

  // Parameter check
  if (ADDR_W != 6) begin : g_bad_addr
    $error("aos_regs serves a 6-bit register address only");
  end

  // Ten-bit result from an offset-corrected half-count sum
  function automatic logic [9:0] sat10(input logic [11:0] half_sum);
    logic [10:0] whole;
    whole = half_sum[11:1];
    if (whole[10] != whole[9]) begin
      sat10 = whole[10] ? 10'h200 : 10'h1FF;
    end else begin
      sat10 = whole[9:0];
    end
  endfunction

  // Byte result, saturating instead of wrapping at the extremes
  function automatic logic [7:0] sat8(input logic [9:0] v);
    if (v[9] && (v[8:7] != 2'b11)) begin
      sat8 = 8'h80;
    end else if (!v[9] && (v[8:7] != 2'b00)) begin
      sat8 = 8'h7F;
    end else begin
      sat8 = v[7:0];
    end
  endfunction

  // Signed add of raw half-count sample and 11-bit trim
  function automatic logic [11:0] add_trim(
    input logic [10:0] raw,
    input logic [10:0] trim
  );
    add_trim = {raw[10], raw} + {trim[10], trim};
  endfunction

  aos_pkg::aos_state_t st_reg;
  aos_pkg::aos_state_t st_next;

  logic rd_hit;
  logic rd_z_low;
  logic rd_out_any;
  logic rd_status;
  logic level_evt;
  logic pulse_evt;
  logic first_interrupt_flag_set;
  logic second_interrupt_flag_set;
  logic clr_level;
  logic clr_pulse;
  logic pulses_valid;

  // Read decode of the strobe in this cycle
  assign rd_hit     = reg_req.rd_en;
  assign rd_z_low   = rd_hit && (reg_req.addr == `AOS_ADDR_Z_LOW);
  assign rd_status  = rd_hit && (reg_req.addr == `AOS_ADDR_STATUS);
  assign rd_out_any = rd_hit &&
                      (reg_req.addr >= `AOS_ADDR_Z_LOW) &&
                      (reg_req.addr <= `AOS_ADDR_Z_BYTE);

  // Interrupt sources per assignment setting
  assign level_evt    = |det_evt.level_hit;
  assign pulse_evt    = |det_evt.pulse_hit;
  assign pulses_valid = !double_pulse_active;

  always_comb begin
    first_interrupt_flag_set  = 1'b0;
    second_interrupt_flag_set  = 1'b0;
    clr_level = 1'b0;
    clr_pulse = 1'b0;
    unique case (interrupt_assignment_field)
      `AOS_ASSIGN_LVL_PUL: begin
        first_interrupt_flag_set  = level_evt;
        second_interrupt_flag_set  = pulse_evt;
        clr_level = first_interrupt_clear;
        clr_pulse = second_interrupt_clear;
      end
      `AOS_ASSIGN_PUL_LVL: begin
        first_interrupt_flag_set  = pulse_evt;
        second_interrupt_flag_set  = level_evt;
        clr_level = second_interrupt_clear;
        clr_pulse = first_interrupt_clear;
      end
      `AOS_ASSIGN_PUL_PUL: begin
        first_interrupt_flag_set  = pulse_evt;
        second_interrupt_flag_set  = double_pulse_active ? det_evt.double_hit
                                        : pulse_evt;
        clr_pulse = first_interrupt_clear ||
                    second_interrupt_clear;
      end
      default: begin
        // Reserved setting: no source assigned
        first_interrupt_flag_set  = 1'b0;
        second_interrupt_flag_set  = 1'b0;
      end
    endcase
  end

  // Next state of the whole bank
  always_comb begin
    st_next          = st_reg;
    st_next.rd_valid = rd_hit;

    // New sample: offset trim applied, ten-bit two's complement
    if (sample_valid) begin
      st_next.x_out = sat10(add_trim(sample_raw.x,
                                     st_reg.x_trim));
      st_next.y_out = sat10(add_trim(sample_raw.y,
                                     st_reg.y_trim));
      st_next.z_out = sat10(add_trim(sample_raw.z,
                                     11'h000));
    end

    // Reading the low Z byte freezes its high bits
    if (rd_z_low) begin
      st_next.z_high_held = st_reg.z_out[9:8];
    end

    // Ready and overrun: reading any output or status clears them,
    // but a sample landing in the same cycle wins
    if (rd_out_any || rd_status) begin
      st_next.ready   = 1'b0;
      st_next.overrun = 1'b0;
    end
    if (sample_valid) begin
      st_next.ready = 1'b1;
      if (st_reg.ready) begin
        st_next.overrun = 1'b1;
      end
    end

    // Parity error is sticky until reset; trim is still applied, self-test stays blocked
    if (trim_parity_error) begin
      st_next.parity_err = 1'b1;
    end

    // Clears first, so that a coincident event still sets
    if (clr_level) begin
      st_next.level_flags = 3'b000;
    end
    if (clr_pulse) begin
      st_next.pulse_flags = 3'b000;
    end
    if (first_interrupt_clear) begin
      st_next.first_interrupt_flag_flag = 1'b0;
    end
    if (second_interrupt_clear) begin
      st_next.second_interrupt_flag_flag = 1'b0;
    end
    st_next.level_flags = st_next.level_flags |
                          det_evt.level_hit;
    if (pulses_valid) begin
      st_next.pulse_flags = st_next.pulse_flags |
                            det_evt.pulse_hit;
    end
    if (first_interrupt_flag_set) begin
      st_next.first_interrupt_flag_flag = 1'b1;
    end
    if (second_interrupt_flag_set) begin
      st_next.second_interrupt_flag_flag = 1'b1;
    end

    // Register writes; read-only offsets ignore them
    if (reg_req.wr_en) begin
      unique case (reg_req.addr)
        `AOS_ADDR_BUS_ADDR: begin
          st_next.two_wire_dis =
            reg_req.wr_data[`AOS_BUSAD_DISABLE];
        end
        `AOS_ADDR_X_OFFSET_TRIM_LOW: begin
          st_next.x_trim[7:0] = reg_req.wr_data;
        end
        `AOS_ADDR_X_OFFSET_TRIM_HIGH: begin
          st_next.x_trim[10:8] = reg_req.wr_data[2:0];
        end
        `AOS_ADDR_Y_OFFSET_TRIM_LOW: begin
          st_next.y_trim[7:0] = reg_req.wr_data;
        end
        `AOS_ADDR_Y_OFFSET_TRIM_HIGH: begin
          st_next.y_trim[10:8] = reg_req.wr_data[2:0];
        end
        default: begin
          st_next.x_trim = st_reg.x_trim;
        end
      endcase
    end

    // Read data, registered so it stands one cycle after the strobe
    if (rd_hit) begin
      unique case (reg_req.addr)
        `AOS_ADDR_Z_LOW: begin
          st_next.rd_data = st_reg.z_out[7:0];
        end
        `AOS_ADDR_Z_HIGH: begin
          st_next.rd_data = {6'h00, st_reg.z_high_held};
        end
        `AOS_ADDR_X_BYTE: begin
          st_next.rd_data = sat8(st_reg.x_out);
        end
        `AOS_ADDR_Y_BYTE: begin
          st_next.rd_data = sat8(st_reg.y_out);
        end
        `AOS_ADDR_Z_BYTE: begin
          st_next.rd_data = sat8(st_reg.z_out);
        end
        `AOS_ADDR_STATUS: begin
          st_next.rd_data = {5'h00, st_reg.parity_err, st_reg.overrun,
                             st_reg.ready};
        end
        `AOS_ADDR_DETECTION_SOURCE: begin
          st_next.rd_data = {st_reg.level_flags, st_reg.pulse_flags,
                             st_reg.second_interrupt_flag_flag,
                             st_reg.first_interrupt_flag_flag};
        end
        `AOS_ADDR_BUS_ADDR: begin
          st_next.rd_data = {st_reg.two_wire_dis, SLAVE_ADDR};
        end
        `AOS_ADDR_USER_INFO: begin
          st_next.rd_data = otp_user_info;
        end
        `AOS_ADDR_IDENT: begin
          st_next.rd_data = otp_ident;
        end
        `AOS_ADDR_X_OFFSET_TRIM_LOW: begin
          st_next.rd_data = st_reg.x_trim[7:0];
        end
        `AOS_ADDR_X_OFFSET_TRIM_HIGH: begin
          st_next.rd_data = {5'h00, st_reg.x_trim[10:8]};
        end
        `AOS_ADDR_Y_OFFSET_TRIM_LOW: begin
          st_next.rd_data = st_reg.y_trim[7:0];
        end
        `AOS_ADDR_Y_OFFSET_TRIM_HIGH: begin
          st_next.rd_data = {5'h00, st_reg.y_trim[10:8]};
        end
        default: begin
          // Offsets outside this bank answer zero
          st_next.rd_data = 8'h00;
        end
      endcase
    end
  end

  // State register, synchronous reset
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      st_reg              <= '0;
      st_reg.x_trim       <= `AOS_RST_TRIM;
      st_reg.y_trim       <= `AOS_RST_TRIM;
      st_reg.rd_data      <= `AOS_RST_BYTE;
      st_reg.two_wire_dis <= 1'b0;
    end else begin
      st_reg <= st_next;
    end
  end

  // Outputs
  assign reg_rd_data          = st_reg.rd_data;
  assign reg_rd_valid         = st_reg.rd_valid;
  assign two_wire_disable_bit = st_reg.two_wire_dis;
  assign self_test_block      = st_reg.parity_err;
  // Ready shares pin one only while the host leaves the routing bit clear
  assign first_int_pin  = st_reg.first_interrupt_flag_flag ||
                          (st_reg.ready && !ready_pin_routing_bit);
  assign second_int_pin = st_reg.second_interrupt_flag_flag;

endmodule

`default_nettype wire

//--- aos_regs_props.sv
/*
  Checker for the output, status, detection and trim bank.
  Assumes it is bound to aos_regs and sees only its ports.
*/
`timescale 1ns/1ps
`default_nettype none
module aos_regs_chk #(
  parameter logic [6:0] SLAVE_ADDR = 7'h1D
) (
  // Clock and reset
  input wire logic                   clk_sys,
  input wire logic                   rst_n,
  // Register port
  input wire aos_pkg::aos_reg_req_t  reg_req,
  input wire logic [7:0]             reg_rd_data,
  // Events and configuration
  input wire logic                   sample_valid,
  input wire aos_pkg::aos_det_evt_t  det_evt,
  input wire logic [1:0]             interrupt_assignment_field,
  input wire logic                   second_interrupt_clear,
  input wire logic                   ready_pin_routing_bit,
  input wire logic                   trim_parity_error,
  input wire logic [7:0]             otp_ident,
  // Outputs
  input wire logic                   two_wire_disable_bit,
  input wire logic                   self_test_block,
  input wire logic                   first_int_pin,
  input wire logic                   second_int_pin
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  // Read-back values of the fixed and partly writable bytes
  AST_IDENT: assert property (
    reg_req.rd_en && reg_req.addr == 6'h0F |=> reg_rd_data == $past(otp_ident))
    else $error("identification byte wrong");
  AST_SLAVE_ADDR: assert property (
    reg_req.rd_en && reg_req.addr == 6'h0D |=> reg_rd_data[6:0] == SLAVE_ADDR)
    else $error("slave address field wrong");
  AST_DISABLE_WR: assert property (
    reg_req.wr_en && reg_req.addr == 6'h0D |=> two_wire_disable_bit == $past(reg_req.wr_data[7]))
    else $error("disable bit not written");
  AST_SPARE_ZERO: assert property (
    reg_req.rd_en && reg_req.addr inside {6'h05, 6'h09, 6'h11, 6'h13}
    |=> reg_rd_data[7:3] == 5'h00) else $error("spare bits not zero");

  // Flags: ready on the pin, sticky parity, interrupt set and clear
  AST_READY_PIN: assert property (
    sample_valid ##1 !ready_pin_routing_bit |-> first_int_pin)
    else $error("ready not shown on first pin");
  AST_PARITY_STICKY: assert property (
    trim_parity_error |=> self_test_block [*3])
    else $error("self-test not blocked");
  AST_PULSE_SECOND_INTERRUPT_FLAG: assert property (
    interrupt_assignment_field == 2'h0 && det_evt.pulse_hit != 3'h0 |=> second_int_pin)
    else $error("pulse did not set second flag");
  AST_CLEAR_SECOND_INTERRUPT_FLAG: assert property (
    second_interrupt_clear && det_evt == '0 |=> !second_int_pin)
    else $error("second flag not cleared");

  cover property (reg_req.rd_en && reg_req.addr == 6'h04 ##[1:4] reg_req.rd_en && reg_req.addr == 6'h05);
  cover property (self_test_block);
  cover property (two_wire_disable_bit);
endmodule
bind aos_regs aos_regs_chk #(.SLAVE_ADDR(SLAVE_ADDR)) u_chk (
  .clk_sys, .rst_n, .reg_req, .reg_rd_data, .sample_valid, .det_evt,
  .interrupt_assignment_field, .second_interrupt_clear, .ready_pin_routing_bit,
  .trim_parity_error, .otp_ident, .two_wire_disable_bit, .self_test_block,
  .first_int_pin, .second_int_pin);
`default_nettype wire

//--- aos_host.sv
/*
  Host model: one-cycle register reads and writes.
  Assumes the bank answers a read one cycle after the strobe.
*/
`timescale 1ns/1ps
`default_nettype none
module aos_host (
  // Clock
  input  wire logic                 clk_sys,
  // Register port
  output var aos_pkg::aos_reg_req_t reg_req,
  input  wire logic [7:0]           reg_rd_data,
  input  wire logic                 reg_rd_valid
);
  initial reg_req = '0;
  // Write strobe held for one whole cycle
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    reg_req = '{1'b1, 1'b0, a, d};
    @(negedge clk_sys);
    reg_req.wr_en = 1'b0;
  endtask
  // Read; the answer stands in the cycle after the strobe, so it is
  // taken there; a missing answer ends the run rather than hanging
  task automatic rd(input logic [5:0] a, output logic [7:0] d);
    @(negedge clk_sys);
    reg_req = '{1'b0, 1'b1, a, 8'h00};
    @(negedge clk_sys);
    d = reg_rd_data;
    reg_req.rd_en = 1'b0;
    if (reg_rd_valid !== 1'b1) begin
      tb_top.miscompares++;
      tb_top.report_and_stop();
    end
  endtask
endmodule
`default_nettype wire

//--- tb_top.sv
/*
  Testbench of the output, status, detection and trim bank.
  Assumes the host model and checker are compiled before it.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam logic [7:0] UINFO = 8'h3C; // Arbitrary fuse value
  localparam logic [7:0] IDENT = 8'h5A; // Arbitrary fuse value
  logic clk_sys = 1'b0, rst_n = 1'b0, sv = 1'b0, tpe = 1'b0, c1 = 1'b0, c2 = 1'b0;
  logic rpb = 1'b0, dpa = 1'b0, valid, twd, stb, ip1, ip2;
  logic [1:0] asg = 2'h0;
  logic [7:0] rdat, v;
  logic [9:0] zo;
  aos_pkg::aos_reg_req_t req;
  aos_pkg::aos_sample_t  raw = '0;
  aos_pkg::aos_det_evt_t det = '0;
  int miscompares = 0;
  int checks = 0;

  always #5 clk_sys = ~clk_sys;

  aos_regs uut (.clk_sys(clk_sys), .rst_n(rst_n), .reg_req(req), .reg_rd_data(rdat),
    .reg_rd_valid(valid), .sample_valid(sv), .sample_raw(raw), .det_evt(det),
    .interrupt_assignment_field(asg), .double_pulse_active(dpa),
    .first_interrupt_clear(c1), .second_interrupt_clear(c2), .ready_pin_routing_bit(rpb),
    .trim_parity_error(tpe), .otp_user_info(UINFO), .otp_ident(IDENT),
    .two_wire_disable_bit(twd), .self_test_block(stb), .first_int_pin(ip1),
    .second_int_pin(ip2));
  aos_host host (.clk_sys(clk_sys), .reg_req(req), .reg_rd_data(rdat), .reg_rd_valid(valid));

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic rc(input logic [5:0] a, input logic [7:0] e);
    host.rd(a, v);
    chk($sformatf("reg %h", a), e, v);
  endtask
  // Reference: half-count sum, halved, saturated to ten bits
  function automatic logic [9:0] ten(input logic [10:0] r, input logic [10:0] t);
    logic signed [11:0] s;
    s = ($signed({r[10], r}) + $signed({t[10], t})) >>> 1;
    if (s > 12'sh1FF) return 10'h1FF;
    if (s < -12'sh200) return 10'h200;
    return s[9:0];
  endfunction
  function automatic logic [7:0] byt(input logic [9:0] o);
    if ($signed(o) > 10'sh07F) return 8'h7F;
    if ($signed(o) < -10'sh080) return 8'h80;
    return o[7:0];
  endfunction
  task automatic smp(input logic [10:0] x, input logic [10:0] y, input logic [10:0] z);
    @(negedge clk_sys);
    raw = {x, y, z};
    sv = 1'b1;
    @(negedge clk_sys);
    sv = 1'b0;
  endtask
  task automatic evt(input aos_pkg::aos_det_evt_t e, input logic k1, input logic k2);
    @(negedge clk_sys);
    det = e;
    c1 = k1;
    c2 = k2;
    @(negedge clk_sys);
    det = '0;
    c1 = 1'b0;
    c2 = 1'b0;
  endtask

  task automatic t_reset;
    for (int a = 4; a < 20; a++) begin
      rc(6'(a), a == 13 ? 8'h1D : a == 14 ? UINFO : a == 15 ? IDENT : 8'h00);
    end
  endtask
  task automatic t_trim;
    host.wr(6'h10, 8'hA5);
    host.wr(6'h11, 8'hFF);
    host.wr(6'h0D, 8'hFF);
    host.wr(6'h0F, 8'h33);
    rc(6'h10, 8'hA5);
    rc(6'h11, 8'h07);
    rc(6'h0D, 8'h9D);
    rc(6'h0F, IDENT);
    chk("disable bit", 8'h01, {7'h0, twd});
    host.wr(6'h0D, 8'h00);
  endtask
  task automatic t_sample;
    smp(11'h190, 11'h000, 11'h5A8);
    chk("first pin", 8'h01, {7'h0, ip1});
    rc(6'h09, 8'h01);
    rc(6'h09, 8'h00);
    chk("first pin", 8'h00, {7'h0, ip1});
    smp(11'h190, 11'h000, 11'h5A8);
    smp(11'h190, 11'h000, 11'h5A8);
    rc(6'h09, 8'h03);
    rc(6'h06, byt(ten(11'h190, 11'h7A5)));
    rc(6'h07, 8'h00);
    rc(6'h08, byt(ten(11'h5A8, 11'h000)));
    zo = ten(11'h5A8, 11'h000);
    rc(6'h04, zo[7:0]);
    smp(11'h000, 11'h000, 11'h0A0);
    rc(6'h05, {6'h00, zo[9:8]});
  endtask
  task automatic t_detect;
    rpb = 1'b1;
    evt('{3'h4, 3'h0, 1'b0}, 1'b0, 1'b0);
    rc(6'h0A, 8'h81);
    chk("first pin", 8'h01, {7'h0, ip1});
    evt('{3'h0, 3'h1, 1'b0}, 1'b0, 1'b0);
    rc(6'h0A, 8'h87);
    evt('0, 1'b1, 1'b0);
    rc(6'h0A, 8'h06);
    chk("first pin", 8'h00, {7'h0, ip1});
    asg = 2'h1;
    evt('{3'h2, 3'h0, 1'b0}, 1'b0, 1'b0);
    rc(6'h0A, 8'h46);
    evt('0, 1'b0, 1'b1);
    rc(6'h0A, 8'h04);
    chk("second pin", 8'h00, {7'h0, ip2});
  endtask
  // Pulse-pulse assignment with double pulse, then no source assigned
  task automatic t_double;
    asg = 2'h2;
    dpa = 1'b1;
    evt('{3'h0, 3'h4, 1'b1}, 1'b0, 1'b0);
    rc(6'h0A, 8'h07);
    evt('0, 1'b1, 1'b1);
    rc(6'h0A, 8'h00);
    asg = 2'h3;
    dpa = 1'b0;
    evt('{3'h1, 3'h1, 1'b0}, 1'b0, 1'b0);
    rc(6'h0A, 8'h24);
  endtask
  task automatic t_parity;
    @(negedge clk_sys);
    tpe = 1'b1;
    @(negedge clk_sys);
    tpe = 1'b0;
    rc(6'h09, 8'h04);
    chk("self-test block", 8'h01, {7'h0, stb});
  endtask

  task automatic report_and_stop;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Reset, then each scenario in turn
  initial begin
    repeat (16) @(posedge clk_sys);
    @(negedge clk_sys);
    rst_n = 1'b1;
    t_reset();
    t_trim();
    t_sample();
    t_detect();
    t_double();
    t_parity();
    report_and_stop();
  end
endmodule
`default_nettype wire
